// File: inc/psd_pkg.sv
package psd_pkg;

  // structure
  localparam int PSD_NUM_CH = 2;
  localparam int PSD_NUM_SRC = 3;
  localparam int PSD_NUM_CLS = 2;
  localparam int PSD_CLS_TR = 0;
  localparam int PSD_CLS_EM = 1;
  localparam int PSD_PER_W = 24;
  localparam int PSD_PW_W = 16;
  localparam int PSD_CNT_W = 31;

  // clock rate
  localparam longint PSD_CLK_HZ = 100_000_000;

  // modulation figures in millihertz
  localparam longint PSD_TR_MHZ = 9_639;
  localparam longint PSD_EM_MHZ = 14_035;
  localparam longint PSD_TOL_MHZ = 255;
  localparam longint PSD_OUT_MHZ = 6_250;

  // times in their own units
  localparam longint PSD_VALID_MS = 500;
  localparam longint PSD_HOLD_SHORT_MS = 4_500;
  localparam longint PSD_HOLD_LONG_MS = 11_000;
  localparam longint PSD_FLASH_MS = 250;
  localparam longint PSD_THR_STEP_NS = 5_000;

  // derived cycle counts; shortest period rounds up, longest rounds down
  localparam int unsigned PSD_TR_PER_MIN =
    32'((PSD_CLK_HZ * 1000 + PSD_TR_MHZ + PSD_TOL_MHZ - 1) / (PSD_TR_MHZ + PSD_TOL_MHZ));
  localparam int unsigned PSD_TR_PER_MAX = 32'((PSD_CLK_HZ * 1000) / (PSD_TR_MHZ - PSD_TOL_MHZ));
  localparam int unsigned PSD_EM_PER_MIN =
    32'((PSD_CLK_HZ * 1000 + PSD_EM_MHZ + PSD_TOL_MHZ - 1) / (PSD_EM_MHZ + PSD_TOL_MHZ));
  localparam int unsigned PSD_EM_PER_MAX = 32'((PSD_CLK_HZ * 1000) / (PSD_EM_MHZ - PSD_TOL_MHZ));
  localparam int unsigned PSD_HALF_CYC = 32'((PSD_CLK_HZ * 1000) / (2 * PSD_OUT_MHZ));
  localparam int unsigned PSD_VALID_CYC = 32'(PSD_VALID_MS * PSD_CLK_HZ / 1000);
  localparam int unsigned PSD_HOLD_SHORT_CYC = 32'(PSD_HOLD_SHORT_MS * PSD_CLK_HZ / 1000);
  localparam int unsigned PSD_HOLD_LONG_CYC = 32'(PSD_HOLD_LONG_MS * PSD_CLK_HZ / 1000);
  localparam int unsigned PSD_FLASH_CYC = 32'(PSD_FLASH_MS * PSD_CLK_HZ / 1000);
  localparam int unsigned PSD_THR_STEP_CYC =
    32'((PSD_THR_STEP_NS * PSD_CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);

  // call tracking per class
  typedef enum logic [1:0] {
    PSD_IDLE,
    PSD_QUAL,
    PSD_CALL,
    PSD_HOLD
  } psd_call_state_t;

endpackage : psd_pkg

// File: rtl/psd_pulse_classifier.sv
`timescale 1ns/1ps
module psd_pulse_classifier
  import psd_pkg::*;
#(
  parameter int unsigned TR_MIN = PSD_TR_PER_MIN,
  parameter int unsigned TR_MAX = PSD_TR_PER_MAX,
  parameter int unsigned EM_MIN = PSD_EM_PER_MIN,
  parameter int unsigned EM_MAX = PSD_EM_PER_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // detector pulse train and width thresholds
  input wire logic det,
  input wire logic [PSD_PW_W-1:0] thr_tr,
  input wire logic [PSD_PW_W-1:0] thr_em,
  // results
  output logic sig_tr,
  output logic sig_em,
  output logic lock_tr,
  output logic lock_em
);

  localparam logic [PSD_PER_W-1:0] TR_LO = PSD_PER_W'(TR_MIN);
  localparam logic [PSD_PER_W-1:0] TR_HI = PSD_PER_W'(TR_MAX);
  localparam logic [PSD_PER_W-1:0] EM_LO = PSD_PER_W'(EM_MIN);
  localparam logic [PSD_PER_W-1:0] EM_HI = PSD_PER_W'(EM_MAX);

  logic det_reg;
  logic [PSD_PER_W-1:0] per_reg;
  logic [PSD_PW_W-1:0] wid_reg;
  logic [PSD_PW_W-1:0] last_wid_reg;
  logic rise, fall, tr_ok, em_ok, tr_tmo, em_tmo;
  logic [PSD_PER_W-1:0] per_now;

  assign rise = det && !det_reg;
  assign fall = !det && det_reg;
  assign per_now = per_reg + 1'b1;
  // period between rising edges against each acceptance window
  assign tr_ok = per_now >= TR_LO && per_now <= TR_HI && last_wid_reg >= thr_tr;
  assign em_ok = per_now >= EM_LO && per_now <= EM_HI && last_wid_reg >= thr_em;
  assign tr_tmo = per_reg >= TR_HI;
  assign em_tmo = per_reg >= EM_HI;

  always_ff @(posedge clk) begin
    det_reg <= srst ? 1'b0 : det;
  end

  // saturating at reset keeps the first edge out of both windows
  always_ff @(posedge clk) begin
    if (srst) begin
      per_reg <= '1;
    end else if (rise) begin
      per_reg <= '0;
    end else if (per_reg != '1) begin
      per_reg <= per_now;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wid_reg <= '0;
      last_wid_reg <= '0;
    end else begin
      if (rise) begin
        wid_reg <= PSD_PW_W'(1);
      end else if (det && wid_reg != '1) begin
        wid_reg <= wid_reg + 1'b1;
      end
      if (fall) begin
        last_wid_reg <= wid_reg;
      end
    end
  end

  // any stray period drops the lock, so mixed transit trains never hold an emergency lock
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_tr <= 1'b0;
      lock_em <= 1'b0;
    end else if (rise) begin
      lock_tr <= tr_ok;
      lock_em <= em_ok;
    end else begin
      lock_tr <= lock_tr && !tr_tmo;
      lock_em <= lock_em && !em_tmo;
    end
  end

  // a pulse above the range threshold lights the signal indicator
  always_ff @(posedge clk) begin
    if (srst) begin
      sig_tr <= 1'b0;
      sig_em <= 1'b0;
    end else begin
      sig_tr <= (fall && wid_reg >= thr_tr) || (sig_tr && !tr_tmo);
      sig_em <= (fall && wid_reg >= thr_em) || (sig_em && !tr_tmo);
    end
  end

endmodule : psd_pulse_classifier

// File: rtl/psd_rate_div.sv
`timescale 1ns/1ps
module psd_rate_div
  import psd_pkg::*;
#(
  parameter int unsigned LIMIT = PSD_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // restart the interval
  input wire logic clr,
  // one-cycle pulse each LIMIT cycles
  output logic tick
);

  localparam logic [PSD_CNT_W-1:0] LAST = PSD_CNT_W'(LIMIT - 1);

  logic [PSD_CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (srst || clr || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = !clr && cnt_reg == LAST;

endmodule : psd_rate_div

// File: rtl/psd_vehicle_preemption.sv
// What this block does
// - Transit and emergency are told apart only by modulation frequency; transit near 9.64 Hz.
// - Accept transit at 9.639 Hz and emergency at 14.035 Hz, each within 0.255 Hz.
// - A coded signal becomes valid only after more than 0.50 s of continuous reception.
// - Mixed transit signals, up to ten or more, never count as emergency.
// - A valid call survives signal loss for 4.5 s or 11 s, selectable.
// - Emergency calls take priority over transit calls when both are present.
// - A transit call drives the output as a 6.25 Hz square wave, 50 % duty.
// - An emergency call holds the output steadily asserted.
// - Asserted output pulls the controller input low; otherwise released, open collector.
// - Two independent channels, each with its own detection state and output.
// - Each channel takes one main and two auxiliary detector inputs.
// - Test switch: down exercises transit, up exercises emergency, centre off.
// - Per class and channel, a signal indicator shows input above threshold.
// - Per class and channel, a call indicator shows a steady valid coded signal.
// - A merged lamp flashes for signal and lights steadily for call.
// - Three range settings per class per channel set the detection threshold.
`timescale 1ns/1ps
module psd_vehicle_preemption
  import psd_pkg::*;
#(
  parameter int unsigned TR_PER_MIN = PSD_TR_PER_MIN,
  parameter int unsigned TR_PER_MAX = PSD_TR_PER_MAX,
  parameter int unsigned EM_PER_MIN = PSD_EM_PER_MIN,
  parameter int unsigned EM_PER_MAX = PSD_EM_PER_MAX,
  parameter int unsigned VALID_CYC = PSD_VALID_CYC,
  parameter int unsigned HOLD_SHORT_CYC = PSD_HOLD_SHORT_CYC,
  parameter int unsigned HOLD_LONG_CYC = PSD_HOLD_LONG_CYC,
  parameter int unsigned HALF_CYC = PSD_HALF_CYC,
  parameter int unsigned FLASH_CYC = PSD_FLASH_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // detector pulse trains
  input wire logic [PSD_NUM_CH-1:0] DET_MAIN,
  input wire logic [PSD_NUM_CH-1:0][1:0] DET_AUX,
  // front panel settings
  input wire logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0][1:0] RANGE_TR,
  input wire logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0][1:0] RANGE_EM,
  input wire logic [PSD_NUM_CH-1:0] HOLD_LONG,
  input wire logic [PSD_NUM_CH-1:0] TEST_DN,
  input wire logic [PSD_NUM_CH-1:0] TEST_UP,
  // controller outputs, open collector
  output logic [PSD_NUM_CH-1:0] PREEMPT_LVL,
  output logic [PSD_NUM_CH-1:0] PREEMPT_DRV_N,
  // front panel indicators
  output logic [PSD_NUM_CH-1:0] SIG_TR,
  output logic [PSD_NUM_CH-1:0] SIG_EM,
  output logic [PSD_NUM_CH-1:0] CALL_TR,
  output logic [PSD_NUM_CH-1:0] CALL_EM,
  output logic [PSD_NUM_CH-1:0] LAMP_TR,
  output logic [PSD_NUM_CH-1:0] LAMP_EM
);

  localparam logic [PSD_CNT_W-1:0] VALID_LIM = PSD_CNT_W'(VALID_CYC);
  localparam logic [PSD_CNT_W-1:0] HOLD_S_LIM = PSD_CNT_W'(HOLD_SHORT_CYC - 1);
  localparam logic [PSD_CNT_W-1:0] HOLD_L_LIM = PSD_CNT_W'(HOLD_LONG_CYC - 1);

  // range code 0 is the most sensitive setting
  function automatic logic [PSD_PW_W-1:0] thr_of(input logic [1:0] code);
    logic [31:0] prod;
    prod = (32'(code) + 32'd1) * PSD_THR_STEP_CYC;
    return prod[PSD_PW_W-1:0];
  endfunction : thr_of

  // per source results
  logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0] det_src;
  logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0] lock_tr;
  logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0] lock_em;
  logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0] sig_tr;
  logic [PSD_NUM_CH-1:0][PSD_NUM_SRC-1:0] sig_em;

  // per class tracking
  logic [PSD_NUM_CH-1:0][PSD_NUM_CLS-1:0] present;
  logic [PSD_NUM_CH-1:0][PSD_NUM_CLS-1:0] call_valid;
  logic [PSD_NUM_CH-1:0][PSD_CNT_W-1:0] hold_lim;
  psd_call_state_t state_reg [PSD_NUM_CH][PSD_NUM_CLS];
  psd_call_state_t state_next [PSD_NUM_CH][PSD_NUM_CLS];
  logic [PSD_CNT_W-1:0] cnt_reg [PSD_NUM_CH][PSD_NUM_CLS];
  logic [PSD_CNT_W-1:0] cnt_next [PSD_NUM_CH][PSD_NUM_CLS];

  // output shaping
  logic [PSD_NUM_CH-1:0] em_on;
  logic [PSD_NUM_CH-1:0] tr_on;
  logic [PSD_NUM_CH-1:0] half_tick;
  logic [PSD_NUM_CH-1:0] phase_reg;
  logic flash_tick;
  logic flash_reg;

  genvar ch, src, cls;

  generate
    for (ch = 0; ch < PSD_NUM_CH; ch++) begin : g_ch
      // main detector plus two auxiliaries
      assign det_src[ch] = {DET_AUX[ch], DET_MAIN[ch]};

      for (src = 0; src < PSD_NUM_SRC; src++) begin : g_src
        psd_pulse_classifier #(
          .TR_MIN(TR_PER_MIN),
          .TR_MAX(TR_PER_MAX),
          .EM_MIN(EM_PER_MIN),
          .EM_MAX(EM_PER_MAX)
        ) u_cls (
          .clk(CLK_SYS),
          .srst(SRST),
          .det(det_src[ch][src]),
          .thr_tr(thr_of(RANGE_TR[ch][src])),
          .thr_em(thr_of(RANGE_EM[ch][src])),
          .sig_tr(sig_tr[ch][src]),
          .sig_em(sig_em[ch][src]),
          .lock_tr(lock_tr[ch][src]),
          .lock_em(lock_em[ch][src])
        );
      end

      // any one source is enough to carry the channel
      assign present[ch][PSD_CLS_TR] = |lock_tr[ch];
      assign present[ch][PSD_CLS_EM] = |lock_em[ch];

      assign hold_lim[ch] = HOLD_LONG[ch] ? HOLD_L_LIM : HOLD_S_LIM;

      for (cls = 0; cls < PSD_NUM_CLS; cls++) begin : g_cls
        always_comb begin
          state_next[ch][cls] = state_reg[ch][cls];
          cnt_next[ch][cls] = cnt_reg[ch][cls];
          case (state_reg[ch][cls])
            PSD_IDLE: begin
              cnt_next[ch][cls] = '0;
              if (present[ch][cls]) begin
                state_next[ch][cls] = PSD_QUAL;
              end
            end
            PSD_QUAL: begin
              // the lock must stay up without a break; one gap restarts it
              if (!present[ch][cls]) begin
                state_next[ch][cls] = PSD_IDLE;
                cnt_next[ch][cls] = '0;
              end else if (cnt_reg[ch][cls] >= VALID_LIM) begin
                state_next[ch][cls] = PSD_CALL;
                cnt_next[ch][cls] = '0;
              end else begin
                cnt_next[ch][cls] = cnt_reg[ch][cls] + 1'b1;
              end
            end
            PSD_CALL: begin
              cnt_next[ch][cls] = '0;
              if (!present[ch][cls]) begin
                state_next[ch][cls] = PSD_HOLD;
              end
            end
            PSD_HOLD: begin
              if (present[ch][cls]) begin
                state_next[ch][cls] = PSD_CALL;
                cnt_next[ch][cls] = '0;
              end else if (cnt_reg[ch][cls] >= hold_lim[ch]) begin
                state_next[ch][cls] = PSD_IDLE;
                cnt_next[ch][cls] = '0;
              end else begin
                cnt_next[ch][cls] = cnt_reg[ch][cls] + 1'b1;
              end
            end
            default: begin
              state_next[ch][cls] = PSD_IDLE;
              cnt_next[ch][cls] = '0;
            end
          endcase
        end

        always_ff @(posedge CLK_SYS) begin
          if (SRST) begin
            state_reg[ch][cls] <= PSD_IDLE;
          end else begin
            state_reg[ch][cls] <= state_next[ch][cls];
          end
        end

        always_ff @(posedge CLK_SYS) begin
          if (SRST) begin
            cnt_reg[ch][cls] <= '0;
          end else begin
            cnt_reg[ch][cls] <= cnt_next[ch][cls];
          end
        end

        assign call_valid[ch][cls] = state_reg[ch][cls] == PSD_CALL || state_reg[ch][cls] == PSD_HOLD;
      end

      // test switch stands in for a valid signal of its class
      assign em_on[ch] = call_valid[ch][PSD_CLS_EM] || TEST_UP[ch];
      // emergency masks transit on the shared output
      assign tr_on[ch] = (call_valid[ch][PSD_CLS_TR] || TEST_DN[ch]) && !em_on[ch];

      // restarting the divider keeps the first asserted half full length
      psd_rate_div #(
        .LIMIT(HALF_CYC)
      ) u_half (
        .clk(CLK_SYS),
        .srst(SRST),
        .clr(!tr_on[ch]),
        .tick(half_tick[ch])
      );

      always_ff @(posedge CLK_SYS) begin
        if (SRST || !tr_on[ch]) begin
          phase_reg[ch] <= 1'b1;
        end else if (half_tick[ch]) begin
          phase_reg[ch] <= !phase_reg[ch];
        end
      end

      // low enable sinks the controller input; high releases it
      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          PREEMPT_DRV_N[ch] <= 1'b1;
        end else begin
          PREEMPT_DRV_N[ch] <= !(em_on[ch] || (tr_on[ch] && phase_reg[ch]));
        end
      end

      // the pin only ever sinks, so its driven level is always low
      always_ff @(posedge CLK_SYS) begin
        PREEMPT_LVL[ch] <= 1'b0;
      end

      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          SIG_TR[ch] <= 1'b0;
          SIG_EM[ch] <= 1'b0;
        end else begin
          SIG_TR[ch] <= |sig_tr[ch];
          SIG_EM[ch] <= |sig_em[ch];
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          CALL_TR[ch] <= 1'b0;
          CALL_EM[ch] <= 1'b0;
        end else begin
          CALL_TR[ch] <= call_valid[ch][PSD_CLS_TR] || TEST_DN[ch];
          CALL_EM[ch] <= em_on[ch];
        end
      end

      // steady for call, flashing for signal only
      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          LAMP_TR[ch] <= 1'b0;
          LAMP_EM[ch] <= 1'b0;
        end else begin
          LAMP_TR[ch] <= call_valid[ch][PSD_CLS_TR] || TEST_DN[ch] || (|sig_tr[ch] && flash_reg);
          LAMP_EM[ch] <= em_on[ch] || (|sig_em[ch] && flash_reg);
        end
      end
    end
  endgenerate

  // one flash rate shared by every lamp so they blink together
  psd_rate_div #(
    .LIMIT(FLASH_CYC)
  ) u_flash (
    .clk(CLK_SYS),
    .srst(SRST),
    .clr(1'b0),
    .tick(flash_tick)
  );

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      flash_reg <= 1'b0;
    end else if (flash_tick) begin
      flash_reg <= !flash_reg;
    end
  end

endmodule : psd_vehicle_preemption

// File: test/psd_emitter_model.sv
`timescale 1ns/1ps
module psd_emitter_model (
  // clock
  input wire logic clk,
  // emission control
  input wire logic run,
  input wire logic [15:0] period,
  input wire logic [15:0] width,
  // detector train and period start
  output logic det,
  output logic start
);
  logic [15:0] cnt_reg;
  // dark detector reads low, and each burst begins on a fresh period
  always_ff @(posedge clk) begin
    if (!run || cnt_reg >= period - 16'h1) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end
  always_ff @(posedge clk) begin
    det <= run && (cnt_reg < width);
  end
  assign start = run && (cnt_reg == 16'h0);
endmodule : psd_emitter_model

// File: test/psd_vehicle_preemption_tb_top.sv
`timescale 1ns/1ps
module psd_vehicle_preemption_tb_top;
  import psd_pkg::*;
  localparam int unsigned HALF = 16;
  localparam int unsigned VALID = 200;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [1:0] test_up = '0;
  logic [1:0] test_dn = '0;
  logic [1:0] hold_long = '0;
  // which sources of each channel see that channel's emitter: bit 0 main, bits 1 and 2 auxiliaries
  logic [2:0] src0 = '0;
  logic [2:0] src1 = '0;
  int lit;
  logic [1:0][2:0][1:0] range_tr = '0;
  logic [1:0][2:0][1:0] range_em = '0;
  logic [1:0] em_run = '0;
  logic [1:0][15:0] em_per = '0;
  logic [1:0][15:0] em_wid = '0;
  logic [1:0] em_det;
  logic [1:0] em_start;
  logic [1:0] lvl, drv_n, sig_tr, sig_em, call_tr, call_em, lamp_tr, lamp_em, ctl_in;
  int bad_count = 0;
  int checks = 0;

  always #5 clk_sys = ~clk_sys;
  // controller input has a pull-up; it is low only while sunk
  assign ctl_in = drv_n | lvl;

  for (genvar e = 0; e < 2; e++) begin : g_em
    psd_emitter_model psd_emitter_model_i (.clk(clk_sys), .run(em_run[e]), .period(em_per[e]), .width(em_wid[e]),
      .det(em_det[e]), .start(em_start[e]));
  end

  psd_vehicle_preemption #(.TR_PER_MIN(2000), .TR_PER_MAX(2400), .EM_PER_MIN(1200), .EM_PER_MAX(1400),
    .VALID_CYC(VALID), .HOLD_SHORT_CYC(400), .HOLD_LONG_CYC(900), .HALF_CYC(HALF), .FLASH_CYC(8)
  ) psd_vehicle_preemption_i (
    .CLK_SYS(clk_sys), .SRST(srst), .DET_MAIN({em_det[1] & src1[0], em_det[0] & src0[0]}),
    .DET_AUX({em_det[1] & src1[2], em_det[1] & src1[1], em_det[0] & src0[2], em_det[0] & src0[1]}),
    .RANGE_TR(range_tr), .RANGE_EM(range_em), .HOLD_LONG(hold_long), .TEST_DN(test_dn), .TEST_UP(test_up),
    .PREEMPT_LVL(lvl), .PREEMPT_DRV_N(drv_n), .SIG_TR(sig_tr), .SIG_EM(sig_em), .CALL_TR(call_tr),
    .CALL_EM(call_em), .LAMP_TR(lamp_tr), .LAMP_EM(lamp_em)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check

  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task do_reset;
    @(posedge clk_sys);
    srst <= 1'b1;
    test_up <= '0;
    test_dn <= '0;
    em_run <= '0;
    step(5);
    @(posedge clk_sys) srst <= 1'b0;
    #1;
  endtask : do_reset

  task emit(input int e, input int per, input int wid);
    @(posedge clk_sys);
    em_per[e] <= 16'(per);
    em_wid[e] <= 16'(wid);
    em_run[e] <= 1'b1;
    #1;
  endtask : emit

  // cut the light just after a period start so loss timing is known
  task stop(input int e);
    int n;
    n = 0;
    while (em_start[e] !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    step(10);
    @(posedge clk_sys) em_run[e] <= 1'b0;
    #1;
  endtask : stop

  task wave(input int ch);
    int lo, hi, n;
    lo = 0;
    hi = 0;
    n = 0;
    while (ctl_in[ch] !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    while (ctl_in[ch] !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    while (ctl_in[ch] === 1'b0 && lo < 100) begin
      step(1);
      lo++;
    end
    while (ctl_in[ch] === 1'b1 && hi < 100) begin
      step(1);
      hi++;
    end
    check(lo, HALF, "transit low phase");
    check(hi, HALF, "transit high phase");
  endtask : wave

  task summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    do_reset;
    check(ctl_in, 2'b11, "released after reset");
    check({sig_em, sig_tr, call_em, call_tr}, 8'h00, "indicators idle");
    @(posedge clk_sys) test_up <= 2'b01;
    step(3);
    check(call_em, 2'b01, "test up call");
    check(lamp_em, 2'b01, "test up lamp");
    step(50);
    check(ctl_in, 2'b10, "emergency steady");
    @(posedge clk_sys) test_dn <= 2'b01;
    step(40);
    check(ctl_in, 2'b10, "emergency wins");
    @(posedge clk_sys) test_up <= 2'b00;
    step(3);
    check(call_tr, 2'b01, "test down call");
    check(lamp_tr, 2'b01, "test down lamp");
    wave(0);
    $display("test switch done");

    do_reset;
    @(posedge clk_sys) src0 <= 3'b111;
    emit(0, 1300, 600);
    step(700);
    check(sig_em, 2'b01, "emergency signal lamp");
    // signal without call: the merged lamp is lit half of each flash period
    lit = 0;
    repeat (16) begin
      step(1);
      lit += lamp_em[0];
    end
    check(lit, 8, "signal lamp flashes");
    step(750);
    check(call_em, 2'b00, "call before validation");
    step(100);
    check(call_em, 2'b01, "emergency call");
    check(call_tr, 2'b00, "no transit call");
    check(ctl_in, 2'b10, "only channel 0 sinks");
    stop(0);
    step(1600);
    check(call_em, 2'b01, "held through loss");
    step(600);
    check(ctl_in, 2'b11, "short hold over");
    $display("emergency detection done");

    do_reset;
    @(posedge clk_sys);
    src1 <= 3'b110;
    hold_long <= 2'b10;
    emit(1, 2200, 600);
    step(2200 + VALID + 100);
    check(call_tr, 2'b10, "transit call from aux");
    check(call_em, 2'b00, "transit never emergency");
    check(sig_tr, 2'b10, "transit signal lamp");
    wave(1);
    stop(1);
    step(3100);
    check(call_tr, 2'b10, "long hold");
    step(400);
    check(call_tr, 2'b00, "long hold over");
    $display("transit detection done");

    for (int k = 0; k < 3; k++) begin
      do_reset;
      @(posedge clk_sys);
      range_em[0] <= (k == 1) ? 6'h3F : 6'h00;
      range_tr[0] <= (k == 2) ? 6'h3F : 6'h00;
      emit(0, (k == 0) ? 1700 : ((k == 1) ? 1300 : 2200), 600);
      step(6000);
      check({call_em, call_tr}, 4'h0, "refused train made a call");
      if (k == 1) check(sig_em, 2'b00, "narrow pulse lit signal");
      if (k == 2) check(sig_tr, 2'b00, "narrow pulse lit transit signal");
    end
    $display("refusals done");
    summarize;
  end

  initial begin
    #500_000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize;
  end
endmodule : psd_vehicle_preemption_tb_top

// File: test/psd_vp_properties.sv
`timescale 1ns/1ps
module psd_vp_properties
  import psd_pkg::*;
#(
  parameter int unsigned HALF_CYC = PSD_HALF_CYC,
  parameter int unsigned VALID_CYC = PSD_VALID_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // test switch
  input wire logic [PSD_NUM_CH-1:0] TEST_DN,
  input wire logic [PSD_NUM_CH-1:0] TEST_UP,
  // outputs watched
  input wire logic [PSD_NUM_CH-1:0] PREEMPT_LVL,
  input wire logic [PSD_NUM_CH-1:0] PREEMPT_DRV_N,
  input wire logic [PSD_NUM_CH-1:0] SIG_EM,
  input wire logic [PSD_NUM_CH-1:0] CALL_TR,
  input wire logic [PSD_NUM_CH-1:0] CALL_EM,
  input wire logic [PSD_NUM_CH-1:0] LAMP_EM
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  for (genvar c = 0; c < PSD_NUM_CH; c++) begin : g_ch
    logic [31:0] low_cnt_reg;
    logic [31:0] sig_cnt_reg;
    // emergency restarts the run so a preemption is not taken for a slow wave
    always_ff @(posedge CLK_SYS) begin
      if (SRST || PREEMPT_DRV_N[c] || CALL_EM[c] || !CALL_TR[c]) begin
        low_cnt_reg <= '0;
      end else begin
        low_cnt_reg <= low_cnt_reg + 32'h1;
      end
    end
    // saturates, only the validation span matters
    always_ff @(posedge CLK_SYS) begin
      if (SRST || !SIG_EM[c]) begin
        sig_cnt_reg <= '0;
      end else if (sig_cnt_reg < VALID_CYC) begin
        sig_cnt_reg <= sig_cnt_reg + 32'h1;
      end
    end
    a_lvl_never_high:
      assert property (PREEMPT_LVL[c] == 1'b0) else $error("collector level not low");
    a_idle_released:
      assert property (!CALL_TR[c] && !CALL_EM[c] && !$past(CALL_TR[c]) && !$past(CALL_EM[c]) |-> PREEMPT_DRV_N[c])
        else $error("output sinking with no call");
    a_em_steady_low:
      assert property (CALL_EM[c] && $past(CALL_EM[c]) |-> !PREEMPT_DRV_N[c]) else $error("emergency output not steady");
    a_em_lamp_steady:
      assert property (CALL_EM[c] && $past(CALL_EM[c]) |-> LAMP_EM[c]) else $error("lamp not steady on call");
    a_test_up_call:
      assert property (TEST_UP[c] [*2] |=> CALL_EM[c]) else $error("test up gave no call");
    a_test_dn_call:
      assert property ((TEST_DN[c] && !TEST_UP[c]) [*2] |=> CALL_TR[c]) else $error("test down gave no call");
    a_tr_half_wave:
      assert property (CALL_TR[c] && !CALL_EM[c] |-> low_cnt_reg <= HALF_CYC) else $error("transit low phase too long");
    a_call_after_valid:
      assert property ($rose(CALL_EM[c]) && !$past(TEST_UP[c]) && !$past(TEST_UP[c], 2) |-> sig_cnt_reg >= VALID_CYC)
        else $error("emergency call before validation");
    c_em_call: cover property ($rose(CALL_EM[c]) && !$past(TEST_UP[c]));
    c_tr_call: cover property ($rose(CALL_TR[c]) && !$past(TEST_DN[c]));
    c_tr_wave: cover property ($rose(PREEMPT_DRV_N[c]) && CALL_TR[c]);
  end
endmodule : psd_vp_properties

bind psd_vehicle_preemption psd_vp_properties #(.HALF_CYC(HALF_CYC), .VALID_CYC(VALID_CYC)) psd_vp_properties_i (
  .CLK_SYS, .SRST, .TEST_DN, .TEST_UP, .PREEMPT_LVL, .PREEMPT_DRV_N, .SIG_EM, .CALL_TR, .CALL_EM, .LAMP_EM
);
